// ===== verilog/ebi_bus_if.sv
// Shared external bus interface: bus master sequencer, slave decode
// and a read data FIFO toward the core.
// Assumes one clock; is_master_in comes from arbitration on that clock
// and changes only while the sequencer is idle.
//
// Contract
// - As master, drive the external address of every access.
// - As slave, take external address as input and decode it.
// - 32-bit words use data bits 47 to 16.
// - 40-bit words use data bits 47 to 8.
// - 16-bit words use data bits 31 to 16.
// - Boot bytes use data bits 23 to 16.
// - Four active-low bank selects, boundaries from programmed bank size.
// - Bank selects decoded from address, changing with the address.
// - Selects idle without access, active even for false conditional.
// - DRAM only in bank 0, using bank-0 select and page signal.
// - Only the bus master drives the bank selects.
// - Read strobe asserted on reads; external readers assert it.
// - Master drives read strobe, others sample it.
// - Write strobe asserted on writes; external writers assert it.
// - Master drives write strobe, others take it as input.
// - Page output asserted when a DRAM access crosses a page.
// - Page only for bank 0 accesses, driven only by master.
// - Only the bus master drives the clock reference.
// - Sync write select gives early warning; no strobe aborts it.
// - Sync write select asserted together with the address.
// - Slaves classify access as write by sync write select; the code marks a write by the write strobe, and select low only blocks reads.
`include "ebi_regs.svh"
`default_nettype none

// Read data FIFO, flip-flop storage; DEPTH must be a power of two
module ebi_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = `EBI_FIFO_DEPTH
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready_out  = (wr_ptr[AW] == rd_ptr[AW]) ||
                         (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_out = (wr_ptr != rd_ptr);
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Pointers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge mclk_in) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data_in;
  end
endmodule

module ebi_bus_if
  import ebi_pkg::*;
#(
  parameter int STROBE_CYCLES = `EBI_STROBE_CYCLES,
  parameter int FIFO_DEPTH    = `EBI_FIFO_DEPTH
) (
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  input  wire logic        is_master_in,
  input  wire logic [4:0]  bank_size_in,
  input  wire logic [4:0]  page_size_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [31:0] req_addr_in,
  input  wire logic        req_write_in,
  input  wire ebi_width_t  req_width_in,
  input  wire logic [39:0] req_wdata_in,
  input  wire logic        req_cond_false_in,
  output logic             rdata_valid_out,
  input  wire logic        rdata_ready_in,
  output logic [39:0]      rdata_out,
  output logic             slave_valid_out,
  output logic             slave_write_out,
  output logic [31:0]      slave_addr_out,
  output logic [39:0]      slave_wdata_out,
  input  wire ebi_width_t  slave_width_in,
  input  wire logic [39:0] slave_rdata_in,
  input  wire logic [31:0] ext_address_in,
  output logic [31:0]      ext_address_out,
  output logic             ext_address_oe_out,
  input  wire logic [47:0] ext_data_in,
  output logic [47:0]      ext_data_out,
  output logic             ext_data_oe_out,
  output logic [3:0]       bank_select_n_out,
  output logic             bank_select_oe_out,
  input  wire logic        read_strobe_n_in,
  output logic             read_strobe_n_out,
  output logic             read_strobe_oe_out,
  input  wire logic        write_strobe_n_in,
  output logic             write_strobe_n_out,
  output logic             write_strobe_oe_out,
  input  wire logic        sync_write_select_n_in,
  output logic             sync_write_select_n_out,
  output logic             sync_write_select_oe_out,
  output logic             page_out,
  output logic             page_oe_out,
  output logic             bus_clock_reference_out,
  output logic             bus_clock_reference_oe_out
);
  localparam int CW = 4;
  localparam int SV = 83;
  localparam int B_SW = 0;
  localparam int B_WR = 1;
  localparam int B_RD = 2;

  // Place a core word on its lanes of the bus
  function automatic logic [47:0] ebi_pack(ebi_width_t w,
                                           logic [39:0] d);
    logic [47:0] b;
    b = 48'h0;
    case (w)
      EBI_W32: b[`EBI_DATA_MSB:`EBI_W32_LSB] = d[31:0];
      EBI_W40: b[`EBI_DATA_MSB:`EBI_W40_LSB] = d;
      EBI_W16: b[`EBI_W16_MSB:`EBI_W16_LSB] = d[15:0];
      EBI_W8:  b[`EBI_W8_MSB:`EBI_W8_LSB] = d[7:0];
      default: b = 48'h0;
    endcase
    return b;
  endfunction

  // Take a core word off its lanes, zero extended
  function automatic logic [39:0] ebi_unpack(ebi_width_t w,
                                             logic [47:0] b);
    logic [39:0] d;
    d = 40'h0;
    case (w)
      EBI_W32: d[31:0] = b[`EBI_DATA_MSB:`EBI_W32_LSB];
      EBI_W40: d = b[`EBI_DATA_MSB:`EBI_W40_LSB];
      EBI_W16: d[15:0] = b[`EBI_W16_MSB:`EBI_W16_LSB];
      EBI_W8:  d[7:0] = b[`EBI_W8_MSB:`EBI_W8_LSB];
      default: d = 40'h0;
    endcase
    return d;
  endfunction

  // Bank select from address; internal space selects no bank
  function automatic logic [3:0] ebi_bank(logic [31:0] a,
                                          logic [4:0] sz);
    logic [31:0] idx;
    idx = (a - `EBI_EXT_BASE) >> sz;
    if (a < `EBI_EXT_BASE || idx > 32'h3) return `EBI_SEL_IDLE;
    return ~(4'h1 << idx[1:0]);
  endfunction

  logic [1:0]  rst_sr;
  logic        rst_n;
  ebi_state_t  state;
  logic [CW-1:0] cnt;
  logic        write_q;
  logic        cond_q;
  ebi_width_t  width_q;
  logic [31:0] last_page;
  logic        page_known;
  logic [31:0] req_page;
  logic [3:0]  req_sel;
  logic        accept;
  logic        rd_done;
  logic        fifo_in_ready;
  logic [SV-1:0] s1;
  logic [SV-1:0] s2;
  logic [SV-1:0] s3;
  logic [2:0]  flt;
  logic [2:0]  flt_d;
  logic        s_hit;
  logic        s_rd_ev;
  logic        s_wr_ev;
  logic        s_rd_pend;
  logic        s_rd_act;

  // Reset release through two flops; assert stays asynchronous
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) rst_sr <= 2'h0;
    else rst_sr <= {rst_sr[0], 1'b1};
  end
  assign rst_n = rst_sr[1];

  // Reads wait for FIFO room so captured data is never dropped
  assign accept = req_valid_in && req_ready_out;
  assign req_ready_out = is_master_in && (state == EBI_IDLE) &&
                         (req_write_in || req_cond_false_in ||
                          fifo_in_ready);
  assign rd_done = (state == EBI_STRB) && (cnt == '0) &&
                   !write_q && !cond_q;
  assign req_sel  = ebi_bank(req_addr_in, bank_size_in);
  assign req_page = req_addr_in >> page_size_in;

  // Master sequencer: address phase, then strobe phase
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state   <= EBI_IDLE;
      cnt     <= '0;
      write_q <= 1'b0;
      cond_q  <= 1'b0;
      width_q <= EBI_W32;
    end else begin
      case (state)
        EBI_IDLE: begin
          if (accept) begin
            state   <= EBI_ADDR;
            write_q <= req_write_in;
            cond_q  <= req_cond_false_in;
            width_q <= req_width_in;
          end
        end
        EBI_ADDR: begin
          state <= EBI_STRB;
          cnt   <= CW'(STROBE_CYCLES - 1);
        end
        EBI_STRB: begin
          if (cnt == '0) state <= EBI_IDLE;
          else cnt <= cnt - 1'b1;
        end
        default: state <= EBI_IDLE;
      endcase
    end
  end

  // Address, bank selects and early write select move together
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_address_out         <= 32'h0;
      bank_select_n_out       <= `EBI_SEL_IDLE;
      sync_write_select_n_out <= `EBI_STRB_IDLE;
    end else if (accept) begin
      ext_address_out         <= req_addr_in;
      bank_select_n_out       <= req_sel;
      sync_write_select_n_out <= !req_write_in;
    end else if (state == EBI_STRB && cnt == '0) begin
      bank_select_n_out       <= `EBI_SEL_IDLE;
      sync_write_select_n_out <= `EBI_STRB_IDLE;
    end
  end

  // Strobes; a false conditional keeps them idle, aborting the cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      read_strobe_n_out  <= `EBI_STRB_IDLE;
      write_strobe_n_out <= `EBI_STRB_IDLE;
    end else if (state == EBI_ADDR) begin
      read_strobe_n_out  <= write_q || cond_q;
      write_strobe_n_out <= !write_q || cond_q;
    end else if (state == EBI_STRB && cnt == '0) begin
      read_strobe_n_out  <= `EBI_STRB_IDLE;
      write_strobe_n_out <= `EBI_STRB_IDLE;
    end
  end

  // Page crossing tracked only for bank 0, the DRAM bank
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      page_out   <= 1'b0;
      last_page  <= 32'h0;
      page_known <= 1'b0;
    end else if (accept && !req_sel[0]) begin
      page_out   <= !page_known || (req_page != last_page);
      last_page  <= req_page;
      page_known <= 1'b1;
    end else if (accept || (state == EBI_STRB && cnt == '0)) begin
      page_out   <= 1'b0;
    end
  end

  // Clock reference: mclk divided by two
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) bus_clock_reference_out <= 1'b0;
    else bus_clock_reference_out <= !bus_clock_reference_out;
  end

  // Only the master drives the shared control and address lines; a slave drives data only to answer a read
  assign ext_address_oe_out       = is_master_in;
  assign bank_select_oe_out       = is_master_in;
  assign read_strobe_oe_out       = is_master_in;
  assign write_strobe_oe_out      = is_master_in;
  assign sync_write_select_oe_out = is_master_in;
  assign page_oe_out              = is_master_in;
  assign bus_clock_reference_oe_out = is_master_in;
  assign ext_data_oe_out = is_master_in ?
                           (write_q && state != EBI_IDLE) :
                           s_rd_act;

  // Pin inputs pass three flops; only s2 reads s1
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
    end else begin
      s1 <= {ext_address_in, ext_data_in, read_strobe_n_in,
             write_strobe_n_in, sync_write_select_n_in};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Strobe levels change once stages two and three agree
  genvar g;
  for (g = 0; g < 3; g++) begin : g_flt
    always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
        flt[g]   <= 1'b1;
        flt_d[g] <= 1'b1;
      end else begin
        if (s2[g] == s3[g]) flt[g] <= s3[g];
        flt_d[g] <= flt[g];
      end
    end
  end

  // Slave decode of internal space; write strobe marks a write, select low blocks reads
  assign s_hit   = !is_master_in && (s3[82:51] < `EBI_INT_TOP);
  assign s_rd_ev = s_hit && flt_d[B_RD] && !flt[B_RD] &&
                   flt[B_SW];
  assign s_wr_ev = s_hit && flt_d[B_WR] && !flt[B_WR];

  // Slave requests toward the core, one-cycle pulse
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      slave_valid_out <= 1'b0;
      slave_write_out <= 1'b0;
      slave_addr_out  <= 32'h0;
      slave_wdata_out <= 40'h0;
    end else begin
      slave_valid_out <= s_rd_ev || s_wr_ev;
      if (s_rd_ev || s_wr_ev) begin
        slave_write_out <= s_wr_ev;
        slave_addr_out  <= s3[82:51];
        slave_wdata_out <= ebi_unpack(slave_width_in, s3[50:3]);
      end
    end
  end

  // Slave read drives data until the reader lifts its strobe
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_rd_pend <= 1'b0;
      s_rd_act  <= 1'b0;
    end else begin
      s_rd_pend <= s_rd_ev;
      if (s_rd_pend) s_rd_act <= 1'b1;
      else if (flt[B_RD] || is_master_in) s_rd_act <= 1'b0;
    end
  end

  // Bus data register: master write data or slave read answer
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) ext_data_out <= 48'h0;
    else if (accept && req_write_in)
      ext_data_out <= ebi_pack(req_width_in, req_wdata_in);
    else if (s_rd_pend)
      ext_data_out <= ebi_pack(slave_width_in, slave_rdata_in);
  end

  ebi_fifo #(
    .WIDTH (40),
    .DEPTH (FIFO_DEPTH)
  ) u_rfifo (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n),
    .in_valid_in   (rd_done),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (ebi_unpack(width_q, s3[50:3])),
    .out_valid_out (rdata_valid_out),
    .out_ready_in  (rdata_ready_in),
    .out_data_out  (rdata_out)
  );

  // Checks
  chk_sel_idle: assert property (@(posedge mclk_in) disable iff (!rst_n)
    state == EBI_IDLE && $past(state) == EBI_IDLE
    |-> bank_select_n_out == 4'hf)
    else $error("bank select active while idle");
  chk_sel_addr: assert property (@(posedge mclk_in) disable iff (!rst_n)
    accept |=> bank_select_n_out == $past(req_sel) &&
    ext_address_out == $past(req_addr_in))
    else $error("bank select not with address");
  chk_sw_early: assert property (@(posedge mclk_in) disable iff (!rst_n)
    accept && req_write_in |=> !sync_write_select_n_out &&
    write_strobe_n_out ##1 !sync_write_select_n_out)
    else $error("sync write select late");
  chk_sw_abort: assert property (@(posedge mclk_in) disable iff (!rst_n)
    accept && req_cond_false_in |=> ##1
    (write_strobe_n_out && read_strobe_n_out) [*2])
    else $error("strobe on false conditional");
  chk_page_bank: assert property (@(posedge mclk_in) disable iff (!rst_n)
    page_out |-> !bank_select_n_out[0])
    else $error("page outside bank 0");
  chk_master_drv: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !is_master_in |-> !bank_select_oe_out && !page_oe_out &&
    !read_strobe_oe_out && !ext_address_oe_out)
    else $error("non-master drives bus");
  chk_rd_len: assert property (@(posedge mclk_in) disable iff (!rst_n)
    $fell(read_strobe_n_out) |-> !read_strobe_n_out [*2]
    ##[1:8] rd_done)
    else $error("read strobe too short");
  chk_lane_w32: assert property (@(posedge mclk_in) disable iff (!rst_n)
    accept && req_write_in && req_width_in == EBI_W32 |=>
    ext_data_out == {$past(req_wdata_in[31:0]), 16'h0})
    else $error("32-bit lanes wrong");
  chk_lane_w8: assert property (@(posedge mclk_in) disable iff (!rst_n)
    accept && req_write_in && req_width_in == EBI_W8 |=>
    ext_data_out == {24'h0, $past(req_wdata_in[7:0]), 16'h0})
    else $error("byte lanes wrong");
  chk_rd_room: assert property (@(posedge mclk_in) disable iff (!rst_n)
    rd_done |-> fifo_in_ready)
    else $error("read data would be lost");
  chk_clk_ref: assert property (@(posedge mclk_in) disable iff (!rst_n)
    bus_clock_reference_out |=> !bus_clock_reference_out)
    else $error("clock reference stalled");
endmodule
`default_nettype wire

// ===== verilog/ebi_regs.svh
// Constants for the shared external bus interface: address map,
// data lane positions, idle values and timing counts.
// Included by the design, not the package; holds definitions only.
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH

// Addresses below this are processor-internal memory and registers
`define EBI_INT_TOP        32'h00800000
// First external bank starts here
`define EBI_EXT_BASE       32'h00800000

// Data lane field positions on the 48-bit bus
`define EBI_DATA_MSB       47
`define EBI_W32_LSB        16
`define EBI_W40_LSB        8
`define EBI_W16_MSB        31
`define EBI_W16_LSB        16
`define EBI_W8_MSB         23
`define EBI_W8_LSB         16

// Idle (reset) values of the bus outputs
`define EBI_SEL_IDLE       4'hf
`define EBI_STRB_IDLE      1'h1

// Strobe length in clock cycles
`define EBI_STROBE_CYCLES  4
// Depth of the read data FIFO
`define EBI_FIFO_DEPTH     8

`endif

// ===== verilog/ebi_pkg.sv
// Types shared by the external bus interface design.
// Assumes ebi_regs.svh is on the include path.
`default_nettype none
package ebi_pkg;
  // Data width modes on the shared bus
  typedef enum logic [1:0] {
    EBI_W32 = 2'h0,
    EBI_W40 = 2'h1,
    EBI_W16 = 2'h2,
    EBI_W8  = 2'h3
  } ebi_width_t;

  // Bus master sequencer states, one-hot
  typedef enum logic [2:0] {
    EBI_IDLE = 3'h1,
    EBI_ADDR = 3'h2,
    EBI_STRB = 3'h4
  } ebi_state_t;
endpackage
`default_nettype wire

// ===== bench/ebi_mem_model.sv
// Behavioural external memory on the shared bus of the interface.
// Assumes the interface is master whenever it reads; one clock.
`default_nettype none
module ebi_mem_model (
  input  wire logic        mclk_in,
  input  wire logic [31:0] ext_address_in,
  input  wire logic        read_strobe_n_in,
  input  wire logic        read_strobe_oe_in,
  output logic      [47:0] ext_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] last = 48'h0;
  logic        drive;

  // Answer only a read strobe that the bus master really drives
  assign drive = !read_strobe_n_in && read_strobe_oe_in;
  // Word made from the address; released bus shows the inverse of the
  // last word so stale data can never pass for a fresh answer
  assign ext_data_out = drive ? {ext_address_in[23:0],
                                 ext_address_in[23:0] ^ 24'h5a5a5a}
                              : ~last;

  // Remember what was last driven
  always_ff @(posedge mclk_in) begin
    if (drive) begin
      last <= ext_data_out;
    end
  end
endmodule
`default_nettype wire

// ===== bench/shared_external_bus_interface_tb_top.sv
// Self-checking bench for the shared external bus interface.
// Assumes the memory model answers master reads; one 125 MHz clock.
`default_nettype none
module shared_external_bus_interface_tb_top
  import ebi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B0 = 32'h00800000;
  localparam int          SC = 4;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, is_master_in = 1'b1;
  logic [4:0]  bank_size_in = 5'h14, page_size_in = 5'h0a;
  logic        req_valid_in = 1'b0, req_write_in = 1'b0;
  logic        req_cond_false_in = 1'b0, rdata_ready_in = 1'b0;
  logic [31:0] req_addr_in = 32'h0, host_addr = 32'h0;
  ebi_width_t  req_width_in = EBI_W32, slave_width_in = EBI_W32;
  logic [39:0] req_wdata_in = 40'h0, slave_rdata_in = 40'h0;
  logic        host_rd_n = 1'b1, host_wr_n = 1'b1, host_sw_n = 1'b1;
  logic [47:0] host_data = 48'h0, mem_data, data_wire, ext_data_out;
  logic [31:0] addr_wire, ext_address_out, slave_addr_out;
  logic [39:0] rdata_out, slave_wdata_out;
  logic [3:0]  bank_select_n_out;
  logic        rd_wire, wr_wire, sw_wire, req_ready_out, rdata_valid_out;
  logic        slave_valid_out, slave_write_out, ext_address_oe_out;
  logic        ext_data_oe_out, bank_select_oe_out, read_strobe_n_out;
  logic        read_strobe_oe_out, write_strobe_n_out, write_strobe_oe_out;
  logic        sync_write_select_n_out, sync_write_select_oe_out, page_out;
  logic        page_oe_out, bus_clock_reference_out;
  logic        bus_clock_reference_oe_out;
  int          miscompares = 0, num_checks = 0;

  // Shared wires: whoever enables its driver sets the level
  assign addr_wire = ext_address_oe_out ? ext_address_out : host_addr;
  assign data_wire = ext_data_oe_out ? ext_data_out
                   : (is_master_in ? mem_data : host_data);
  assign rd_wire = read_strobe_oe_out ? read_strobe_n_out : host_rd_n;
  assign wr_wire = write_strobe_oe_out ? write_strobe_n_out : host_wr_n;
  assign sw_wire = sync_write_select_oe_out ? sync_write_select_n_out
                 : host_sw_n;

  // Clock at 125 MHz
  always #4 mclk_in = ~mclk_in;

  ebi_bus_if #(.STROBE_CYCLES(SC), .FIFO_DEPTH(8)) u_ebi_bus_if (
    .mclk_in, .resetn_in, .is_master_in, .bank_size_in, .page_size_in,
    .req_valid_in, .req_ready_out, .req_addr_in, .req_write_in,
    .req_width_in, .req_wdata_in, .req_cond_false_in, .rdata_valid_out,
    .rdata_ready_in, .rdata_out, .slave_valid_out, .slave_write_out,
    .slave_addr_out, .slave_wdata_out, .slave_width_in, .slave_rdata_in,
    .ext_address_in(addr_wire), .ext_address_out, .ext_address_oe_out,
    .ext_data_in(data_wire), .ext_data_out, .ext_data_oe_out,
    .bank_select_n_out, .bank_select_oe_out, .read_strobe_n_in(rd_wire),
    .read_strobe_n_out, .read_strobe_oe_out, .write_strobe_n_in(wr_wire),
    .write_strobe_n_out, .write_strobe_oe_out,
    .sync_write_select_n_in(sw_wire), .sync_write_select_n_out,
    .sync_write_select_oe_out, .page_out, .page_oe_out,
    .bus_clock_reference_out, .bus_clock_reference_oe_out);

  ebi_mem_model u_ebi_mem_model (
    .mclk_in, .ext_address_in(addr_wire), .read_strobe_n_in(rd_wire),
    .read_strobe_oe_in(read_strobe_oe_out), .ext_data_out(mem_data));

  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // Lane placement of a low-justified word on the 48-bit bus
  function automatic logic [47:0] lanes(ebi_width_t w, logic [39:0] d);
    case (w)
      EBI_W32: lanes = {d[31:0], 16'h0};
      EBI_W40: lanes = {d, 8'h0};
      EBI_W16: lanes = {16'h0, d[15:0], 16'h0};
      default: lanes = {24'h0, d[7:0], 16'h0};
    endcase
  endfunction

  // What the memory model returns on a 40-bit read
  function automatic logic [39:0] rd_exp(logic [31:0] a);
    rd_exp = {a[23:0], a[23:8] ^ 16'h5a5a};
  endfunction

  // Bounded wait for a flag, sampled mid-cycle
  task automatic wait_for(ref logic flag, input int lim);
    for (int n = 0; n < lim && flag !== 1'b1; n++) begin
      @(negedge mclk_in);
    end
  endtask

  // One master access: address phase, strobe phase, release
  task automatic access(input logic [31:0] a, input logic wr,
      input ebi_width_t w, input logic [39:0] d, input logic cf,
      input logic [3:0] sel, input logic pg);
    @(posedge mclk_in);
    req_addr_in <= a;
    req_write_in <= wr;
    req_width_in <= w;
    req_wdata_in <= d;
    req_cond_false_in <= cf;
    req_valid_in <= 1'b1;
    @(negedge mclk_in);
    wait_for(req_ready_out, 50);
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    repeat (2) @(negedge mclk_in);
    chk("address", a, ext_address_out);
    chk("selects", sel, bank_select_n_out);
    chk("sync write", !wr, sync_write_select_n_out);
    chk("page", pg, page_out);
    if (wr) chk("write lanes", lanes(w, d), ext_data_out);
    @(negedge mclk_in);
    chk("write strobe", !(wr && !cf), write_strobe_n_out);
    chk("read strobe", !(!wr && !cf), read_strobe_n_out);
    repeat (SC) @(negedge mclk_in);
    chk("selects idle", 4'hf, bank_select_n_out);
    chk("strobes idle", 3'h7, {read_strobe_n_out, write_strobe_n_out,
        sync_write_select_n_out});
  endtask

  // Take one word from the read FIFO and compare it
  task automatic pop(input logic [39:0] exp);
    @(negedge mclk_in);
    wait_for(rdata_valid_out, 20);
    chk("read valid", 1'b1, rdata_valid_out);
    chk("read data", exp, rdata_out);
    @(posedge mclk_in);
    rdata_ready_in <= 1'b1;
    @(posedge mclk_in);
    rdata_ready_in <= 1'b0;
  endtask

  task automatic t_reset();
    logic c;
    @(negedge mclk_in);
    chk("idle pins", 7'h7e, {bank_select_n_out, read_strobe_n_out,
        write_strobe_n_out, page_out});
    chk("master enables", 7'h7f, {ext_address_oe_out, bank_select_oe_out,
        read_strobe_oe_out, write_strobe_oe_out, sync_write_select_oe_out,
        page_oe_out, bus_clock_reference_oe_out});
    c = bus_clock_reference_out;
    @(negedge mclk_in);
    chk("clock reference", !c, bus_clock_reference_out);
    $display("test reset done");
  endtask

  // Every lane mode, one bank each, then conditional and unmapped
  task automatic t_write();
    for (int i = 0; i < 4; i++) begin
      access(B0 + (32'(i) << 20) + 32'h40, 1'b1, ebi_width_t'(2'(i)),
             40'hc3a59617e8, 1'b0, ~(4'h1 << i), i == 0);
    end
    access(B0 + 32'h00200000, 1'b1, EBI_W32, 40'h1, 1'b1, 4'hb,
           1'b0);
    access(B0 + 32'h00300000, 1'b0, EBI_W32, 40'h0, 1'b1, 4'h7,
           1'b0);
    access(B0 + 32'h00400000, 1'b1, EBI_W40, 40'h2, 1'b0, 4'hf,
           1'b0);
    $display("test write lanes done");
  endtask

  // Bank 0 reads: same page, then a new page
  task automatic t_read();
    access(B0 + 32'h80, 1'b0, EBI_W40, 40'h0, 1'b0, 4'he, 1'b0);
    pop(rd_exp(B0 + 32'h80));
    access(B0 + 32'h400, 1'b0, EBI_W40, 40'h0, 1'b0, 4'he, 1'b1);
    pop(rd_exp(B0 + 32'h400));
    $display("test read page done");
  endtask

  // Fill the read FIFO until refused, then drain it
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) begin
      access(B0 + 32'h00100000 + 32'(i * 4), 1'b0, EBI_W40, 40'h0, 1'b0,
             4'hd, 1'b0);
    end
    chk("ready when full", 1'b0, req_ready_out);
    for (int i = 0; i < 8; i++) begin
      pop(rd_exp(B0 + 32'h00100000 + 32'(i * 4)));
    end
    @(negedge mclk_in);
    chk("ready when drained", 1'b1, req_ready_out);
    $display("test fifo done");
  endtask

  // Host side: write, read, then an address outside internal space
  task automatic t_slave();
    int seen;
    @(posedge mclk_in);
    is_master_in <= 1'b0;
    @(negedge mclk_in);
    chk("slave enables", 7'h0, {ext_address_oe_out, bank_select_oe_out,
        read_strobe_oe_out, write_strobe_oe_out, sync_write_select_oe_out,
        page_oe_out, bus_clock_reference_oe_out});
    chk("slave ready", 1'b0, req_ready_out);
    @(posedge mclk_in);
    host_addr <= 32'h120;
    host_data <= lanes(EBI_W32, 40'h001234abcd);
    host_sw_n <= 1'b0;
    @(posedge mclk_in);
    host_wr_n <= 1'b0;
    wait_for(slave_valid_out, 12);
    chk("host write kind", 2'h3, {slave_valid_out,
        slave_write_out});
    chk("host write addr", 32'h120, slave_addr_out);
    chk("host write data", 40'h001234abcd, slave_wdata_out);
    repeat (4) @(posedge mclk_in);
    host_wr_n <= 1'b1;
    host_sw_n <= 1'b1;
    slave_rdata_in <= 40'h0055aa66cc;
    repeat (4) @(posedge mclk_in);
    host_rd_n <= 1'b0;
    wait_for(slave_valid_out, 12);
    chk("host read kind", 2'h2, {slave_valid_out, slave_write_out});
    wait_for(ext_data_oe_out, 6);
    chk("host read drive", 1'b1, ext_data_oe_out);
    chk("host read data", lanes(EBI_W32, 40'h0055aa66cc),
        ext_data_out);
    @(posedge mclk_in);
    host_rd_n <= 1'b1;
    host_addr <= B0;
    repeat (6) @(posedge mclk_in);
    host_wr_n <= 1'b0;
    seen = 0;
    repeat (12) begin
      @(negedge mclk_in);
      seen += int'(slave_valid_out === 1'b1);
    end
    chk("outside space ignored", 48'h0, 48'(seen));
    @(posedge mclk_in);
    host_wr_n <= 1'b1;
    $display("test slave done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: reset, then every scenario in turn
  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    t_reset();
    t_write();
    t_read();
    t_fifo();
    t_slave();
    give_verdict();
  end

  // Watchdog: whole run needs well under 1000 cycles
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
